// ==== design/ssl_regs.svh ====
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// Register byte offsets
`define SSL_OFS_CTRL   8'h00
`define SSL_OFS_BAUD   8'h04
`define SSL_OFS_TXBUF  8'h08
`define SSL_OFS_RXBUF  8'h0c
`define SSL_OFS_EIC    8'h10
`define SSL_OFS_STAT   8'h14
`define SSL_OFS_DIR    8'h18

// Control register fields
`define SSL_CTRL_EN      0
`define SSL_CTRL_MS      1
`define SSL_CTRL_ENB_HI  7
`define SSL_CTRL_ENB_LO  4
`define SSL_CTRL_FLG_HI  11
`define SSL_CTRL_FLG_LO  8
`define SSL_CTRL_WID_HI  15
`define SSL_CTRL_WID_LO  12

// Status, interrupt control and direction fields
`define SSL_STAT_TXE   0
`define SSL_STAT_RXF   1
`define SSL_STAT_BUSY  2
`define SSL_EIC_REQ    0
`define SSL_EIC_EN     1
`define SSL_DIR_SCLK   0
`define SSL_DIR_MOSI   1
`define SSL_DIR_MISO   2

// Reset values
`define SSL_BAUD_RST   16'h0007
`define SSL_WID_RST    4'hf
`define SSL_DIR_RST    3'h0

`endif

// ==== design/ssl_pkg.sv ====
package ssl_pkg;

  typedef enum logic [3:0]
  {
    SSL_IDLE  = 4'b0001,
    SSL_START = 4'b0010,
    SSL_LOW   = 4'b0100,
    SSL_HIGH  = 4'b1000
  } ssl_state_t;

  // Order matches control register bits tx, rx, phase, baud (msb first)
  typedef struct packed
  {
    logic tx;
    logic rx;
    logic ph;
    logic bd;
  } ssl_err_t;

  typedef struct packed
  {
    logic sclk;
    logic mosi;
    logic miso;
  } ssl_pins_t;

endpackage : ssl_pkg

// ==== design/ssl_core.sv ====
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ssl_regs.svh"

module ssl_core
  import ssl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        master_out_slave_in_pin_in,
  output logic             master_out_slave_in_pin_out,
  output logic             master_out_slave_in_pin_oe,
  input  wire logic        master_in_slave_out_pin_in,
  output logic             master_in_slave_out_pin_out,
  output logic             master_in_slave_out_pin_oe,
  input  wire logic        error_interrupt_ack,
  output logic             error_interrupt
);

  function automatic logic [15:0] ssl_mask(input logic [3:0] w);
    ssl_mask = 16'hffff >> (4'hf - w);
  endfunction : ssl_mask

  function automatic logic ssl_msb(input logic [15:0] v, input logic [3:0] w);
    ssl_msb = v[w];
  endfunction : ssl_msb

  logic        channel_enable_q, master_select_q;
  ssl_err_t    error_enable_bits_q, error_indication_flags_q, err_set, sw_set;
  logic [3:0]  wsel_q;
  logic [15:0] baud_q, transmit_buffer_q, receive_buffer_q, sr_q;
  logic        tx_full_q, tx_fresh_q, rx_full_q, eic_req_q, eic_en_q;
  logic [2:0]  dir_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  ssl_state_t  st_q;
  logic [4:0]  cnt_q;
  logic [15:0] div_q;
  logic        lat_q, ph_ref_q, ph_chk_q, din_prev_q;
  logic [17:0] gap_q;
  ssl_pins_t   s1_q, s2_q;
  logic        sclk_s3_q;
  ssl_pins_t   out_q;
  logic        irq_q;

  logic        addr_ph, wr_ctrl, wr_tx, rd_rx, m_act, s_act, tick;
  logic        s_rise, s_fall, din, latch_ev, shift_ev, m_end, s_end, frame_end;
  logic        m_load, s_load, load_ev, bd_reset, too_fast, too_slow, busy;
  logic [16:0] half;
  logic [15:0] rx_val, ld_val;

  // Slave receives on mosi, master on miso; own bits come back on a shared line
  assign din      = master_select_q ? s2_q.miso : s2_q.mosi;
  assign addr_ph  = hsel & htrans[1] & hready;
  assign wr_ctrl  = wr_pend_q & (wr_addr_q == `SSL_OFS_CTRL);
  assign wr_tx    = wr_pend_q & (wr_addr_q == `SSL_OFS_TXBUF);
  assign rd_rx    = addr_ph & ~hwrite & (haddr[7:0] == `SSL_OFS_RXBUF);
  assign m_act    = channel_enable_q & master_select_q;
  assign s_act    = channel_enable_q & ~master_select_q;
  assign tick     = (div_q == baud_q);
  assign s_rise   = s_act & s2_q.sclk & ~sclk_s3_q;
  assign s_fall   = s_act & ~s2_q.sclk & sclk_s3_q;
  assign m_end    = m_act & (st_q == SSL_HIGH) & tick & (cnt_q == ({1'b0, wsel_q} + 5'h01));
  assign s_end    = s_rise & (cnt_q == {1'b0, wsel_q});
  assign frame_end = m_end | s_end;
  assign latch_ev = m_act ? ((st_q == SSL_LOW) & tick) : s_rise;
  assign shift_ev = m_act ? ((st_q == SSL_HIGH) & tick & ~m_end) : (s_fall & (cnt_q != 5'h00));
  assign m_load   = m_act & tx_full_q & (((st_q == SSL_IDLE)) | m_end);
  assign s_load   = s_act & tx_full_q & (cnt_q == 5'h00) & ~s_rise & ~s_fall;
  assign load_ev  = m_load | s_load;
  assign ld_val   = transmit_buffer_q & ssl_mask(wsel_q);
  assign rx_val   = {sr_q[14:0], (m_act ? lat_q : din)} & ssl_mask(wsel_q);
  assign half     = {1'b0, baud_q} + 17'h00001;
  assign too_fast = ({1'b0, gap_q} + 19'h00001) < {2'b00, half[16:1]};
  assign too_slow = gap_q > {half, 1'b0};
  assign busy     = (st_q != SSL_IDLE) | (cnt_q != 5'h00);

  // Slave checks transmit freshness and clock rate; master only rx and phase
  always_comb
  begin
    err_set.tx = s_rise & (cnt_q == 5'h00) & ~tx_fresh_q;
    err_set.rx = frame_end & rx_full_q;
    err_set.ph = channel_enable_q & ph_chk_q & (din != ph_ref_q);
    err_set.bd = s_act & (cnt_q != 5'h00) & (((s_rise | s_fall) & too_fast) | too_slow);
    sw_set     = wr_ctrl & channel_enable_q ? (hwdata[`SSL_CTRL_FLG_HI:`SSL_CTRL_FLG_LO]
                 & ~error_indication_flags_q & error_enable_bits_q) : 4'h0;
  end

  assign bd_reset = err_set.bd & error_enable_bits_q.bd;

  // Bus: zero wait state; reads decoded in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= addr_ph & hwrite;
      wr_addr_q <= haddr[7:0];
      if (addr_ph & ~hwrite)
      begin
        case (haddr[7:0])
          `SSL_OFS_CTRL:  hrdata_q <= {16'h0000, wsel_q,
                                       channel_enable_q ? error_indication_flags_q : 4'h0,
                                       error_enable_bits_q, 2'b00, master_select_q, channel_enable_q};
          `SSL_OFS_BAUD:  hrdata_q <= {16'h0000, baud_q};
          `SSL_OFS_TXBUF: hrdata_q <= {16'h0000, transmit_buffer_q};
          `SSL_OFS_RXBUF: hrdata_q <= {16'h0000, receive_buffer_q};
          `SSL_OFS_EIC:   hrdata_q <= {30'h0000_0000, eic_en_q, eic_req_q};
          `SSL_OFS_STAT:  hrdata_q <= {29'h0000_0000, busy, rx_full_q, ~tx_full_q};
          `SSL_OFS_DIR:   hrdata_q <= {29'h0000_0000, dir_q};
          default:        hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration; width and enables only change while the channel is off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      channel_enable_q    <= 1'b0;
      master_select_q     <= 1'b0;
      error_enable_bits_q <= 4'h0;
      wsel_q              <= `SSL_WID_RST;
      baud_q              <= `SSL_BAUD_RST;
      dir_q               <= `SSL_DIR_RST;
      eic_en_q            <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        channel_enable_q <= hwdata[`SSL_CTRL_EN];
        master_select_q  <= hwdata[`SSL_CTRL_MS];
        if (!channel_enable_q)
        begin
          error_enable_bits_q <= hwdata[`SSL_CTRL_ENB_HI:`SSL_CTRL_ENB_LO];
          wsel_q              <= hwdata[`SSL_CTRL_WID_HI:`SSL_CTRL_WID_LO];
        end
      end
      if (wr_pend_q & (wr_addr_q == `SSL_OFS_BAUD))
        baud_q <= hwdata[15:0];
      if (wr_pend_q & (wr_addr_q == `SSL_OFS_DIR))
        dir_q <= hwdata[2:0];
      if (wr_pend_q & (wr_addr_q == `SSL_OFS_EIC))
        eic_en_q <= hwdata[`SSL_EIC_EN];
    end
  end

  // Error flags and shared request; hardware set wins over any clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      error_indication_flags_q <= 4'h0;
      eic_req_q                <= 1'b0;
      irq_q                    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl & channel_enable_q)
        error_indication_flags_q <= hwdata[`SSL_CTRL_FLG_HI:`SSL_CTRL_FLG_LO] | err_set;
      else
        error_indication_flags_q <= error_indication_flags_q | err_set;
      if (((err_set & error_enable_bits_q) != 4'h0) | (sw_set != 4'h0))
        eic_req_q <= 1'b1;
      else if (error_interrupt_ack)
        eic_req_q <= 1'b0;
      else if (wr_pend_q & (wr_addr_q == `SSL_OFS_EIC))
        eic_req_q <= hwdata[`SSL_EIC_REQ];
      irq_q <= eic_req_q & eic_en_q;
    end
  end

  // Buffers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transmit_buffer_q <= 16'h0000;
      tx_full_q         <= 1'b0;
      tx_fresh_q        <= 1'b0;
      receive_buffer_q  <= 16'h0000;
      rx_full_q         <= 1'b0;
    end
    else
    begin
      if (wr_tx)
        transmit_buffer_q <= hwdata[15:0];
      // Stored while disabled but never armed
      if (wr_tx & channel_enable_q)
        tx_full_q <= 1'b1;
      else if (load_ev | ~channel_enable_q)
        tx_full_q <= 1'b0;
      if (wr_tx & channel_enable_q)
        tx_fresh_q <= 1'b1;
      else if (s_rise & (cnt_q == 5'h00))
        tx_fresh_q <= 1'b0;
      if (frame_end & ~bd_reset)
        receive_buffer_q <= rx_val;
      if (frame_end & ~bd_reset)
        rx_full_q <= 1'b1;
      else if (rd_rx)
        rx_full_q <= 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q       <= 3'h0;
      s2_q       <= 3'h0;
      sclk_s3_q  <= 1'b0;
      din_prev_q <= 1'b0;
    end
    else
    begin
      s1_q       <= {sclk_in, master_out_slave_in_pin_in, master_in_slave_out_pin_in};
      s2_q       <= s1_q;
      sclk_s3_q  <= s2_q.sclk;
      din_prev_q <= din;
    end
  end

  // Master sequencer and baud divider
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q  <= SSL_IDLE;
      div_q <= 16'h0000;
    end
    else
    begin
      div_q <= (tick | (st_q == SSL_IDLE)) ? 16'h0000 : div_q + 16'h0001;
      if (!m_act)
        st_q <= SSL_IDLE;
      else
      begin
        case (st_q)
          SSL_IDLE:  st_q <= tx_full_q ? SSL_START : SSL_IDLE;
          SSL_START: st_q <= tick ? SSL_LOW : SSL_START;
          SSL_LOW:   st_q <= tick ? SSL_HIGH : SSL_LOW;
          SSL_HIGH:  st_q <= !tick ? SSL_HIGH : ((m_end & ~tx_full_q) ? SSL_IDLE : SSL_LOW);
          default:   st_q <= SSL_IDLE;
        endcase
      end
    end
  end

  // Shift register, bit count, phase and rate checks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sr_q     <= 16'h0000;
      cnt_q    <= 5'h00;
      lat_q    <= 1'b0;
      ph_ref_q <= 1'b0;
      ph_chk_q <= 1'b0;
      gap_q    <= 18'h00000;
    end
    else
    begin
      // Slave keeps the whole received word, so an unrefreshed frame echoes it
      if (load_ev)
        sr_q <= ld_val;
      else if (s_end)
        sr_q <= rx_val;
      else if (shift_ev)
        sr_q <= {sr_q[14:0], lat_q};
      if (bd_reset | ~channel_enable_q | frame_end)
        cnt_q <= 5'h00;
      else if (latch_ev)
        cnt_q <= cnt_q + 5'h01;
      if (latch_ev)
        lat_q <= din;
      ph_chk_q <= latch_ev;
      if (latch_ev)
        ph_ref_q <= din_prev_q;
      if (bd_reset | s_rise | s_fall | (cnt_q == 5'h00) | ~s_act)
        gap_q <= 18'h00000;
      else
        gap_q <= gap_q + 18'h00001;
    end
  end

  // Pin outputs; only the unused role's data line is held high, directions are software's job
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_q <= 3'b011;
    else
    begin
      out_q.sclk <= m_act & (st_q == SSL_HIGH);
      out_q.mosi <= m_act ? ssl_msb(sr_q, wsel_q) : 1'b1;
      out_q.miso <= s_act ? ssl_msb(sr_q, wsel_q) : 1'b1;
    end
  end

  assign hreadyout                   = 1'b1;
  assign hresp                       = 1'b0;
  assign hrdata                      = hrdata_q;
  assign sclk_out                    = out_q.sclk;
  assign master_out_slave_in_pin_out = out_q.mosi;
  assign master_in_slave_out_pin_out = out_q.miso;
  assign sclk_oe                     = dir_q[`SSL_DIR_SCLK];
  assign master_out_slave_in_pin_oe  = dir_q[`SSL_DIR_MOSI];
  assign master_in_slave_out_pin_oe  = dir_q[`SSL_DIR_MISO];
  assign error_interrupt             = irq_q;

  AST_TX_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_tx & ~channel_enable_q & ~tx_full_q) |=> ~tx_full_q)
    else $error("tx write while disabled armed a transfer");
  AST_RX_OVERRUN: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_end & rx_full_q & channel_enable_q) |=> error_indication_flags_q.rx)
    else $error("overrun did not set receive error");
  AST_REQ_ENABLED: assert property (@(posedge hclk) disable iff (!hresetn)
    ((err_set & error_enable_bits_q) != 4'h0) |=> eic_req_q ##1 (irq_q == eic_en_q))
    else $error("enabled error gave no request");
  AST_FLAG_ALWAYS: assert property (@(posedge hclk) disable iff (!hresetn)
    (err_set.ph & channel_enable_q) |=> error_indication_flags_q.ph)
    else $error("phase error flag not set");
  AST_MASTER_ERRS: assert property (@(posedge hclk) disable iff (!hresetn)
    master_select_q |-> (!err_set.tx && !err_set.bd))
    else $error("slave-only error in master mode");
  AST_ACK_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (error_interrupt_ack & (err_set == 4'h0) & (sw_set == 4'h0)) |=> ~eic_req_q)
    else $error("service did not clear request");
  AST_BAUD_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    bd_reset |=> (cnt_q == 5'h00) && (gap_q == 18'h00000))
    else $error("baud error did not reset channel");
  AST_NO_GAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (m_end & tx_full_q & m_act) |=> (st_q == SSL_LOW) && (sr_q == $past(ld_val)))
    else $error("back to back frame had a gap");
  AST_SW_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (sw_set != 4'h0) |=> eic_req_q)
    else $error("software flag set gave no request");
  AST_ENB_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl & channel_enable_q) |=> $stable(error_enable_bits_q) && $stable(wsel_q))
    else $error("enables changed while enabled");

endmodule : ssl_core

`default_nettype wire

// ==== test/ssl_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssl_far_model (
  input  wire logic is_master,
  input  wire logic sclk_l,
  input  wire logic mosi_l,
  input  wire logic miso_l,
  output logic      sclk_o,
  output logic      data_o,
  output logic      sclk_e,
  output logic      mosi_e,
  output logic      miso_e
);
  logic [15:0] tx_q = 16'hffff;
  logic [15:0] rx_q = 16'h0000;
  realtime     last_t = 0;
  realtime     max_gap = 0;
  // Sole master owns clock and data out; a slave drives only its return line
  assign sclk_e = is_master;
  assign mosi_e = is_master;
  assign miso_e = !is_master;
  assign data_o = tx_q[15];
  initial sclk_o = 1'b0;
  task automatic preset(input logic [15:0] tx);
    tx_q = tx;
    rx_q = 16'h0000;
    last_t = 0;
    max_gap = 0;
  endtask : preset
  // Clock stands low between frames
  task automatic xfer(input int nb, input realtime half);
    repeat (nb)
    begin
      #half sclk_o = 1'b1;
      #half sclk_o = 1'b0;
    end
  endtask : xfer
  // Data moves together with the rising edge, inside the receiver's latch window
  task automatic skew(input realtime half);
    #half;
    sclk_o = 1'b1;
    tx_q   = ~tx_q;
    #half sclk_o = 1'b0;
  endtask : skew
  always @(posedge sclk_l)
  begin
    rx_q <= {rx_q[14:0], is_master ? miso_l : mosi_l};
    if (last_t > 0 && $realtime - last_t > max_gap)
      max_gap = $realtime - last_t;
    last_t = $realtime;
  end
  // Ones refill so an idle data line rests high
  always @(negedge sclk_l)
    tx_q <= {tx_q[14:0], 1'b1};
endmodule : ssl_far_model
`default_nettype wire

// ==== test/ssl_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssl_regs.svh"
module ssl_core_tb
  import ssl_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ack = 1'b0, loop = 1'b0;
  logic        m_mst = 1'b0, junk_q = 1'b0, hreadyout, eint, sclk_out, sclk_oe, mo_out, mo_oe, mi_out, mi_oe;
  logic        m_sclk, m_data, m_se, m_moe, m_mie, hresp;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  ssl_pins_t   ln;
  int          err_total = 0, check_count = 0;

  always #4 hclk = ~hclk;
  always @(posedge hclk)
    junk_q <= ~junk_q;
  // Released lines toggle so a stale level can never pass for data
  always_comb
  begin
    ln.sclk = sclk_oe ? sclk_out : m_se ? m_sclk : junk_q;
    ln.mosi = mo_oe ? mo_out : m_moe ? m_data : junk_q;
    ln.miso = loop ? ln.mosi : mi_oe ? mi_out : m_mie ? m_data : junk_q;
  end

  ssl_core ssl_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclk_in(ln.sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .error_interrupt_ack(ack),
    .master_out_slave_in_pin_in(ln.mosi), .master_out_slave_in_pin_out(mo_out), .master_out_slave_in_pin_oe(mo_oe),
    .master_in_slave_out_pin_in(ln.miso), .master_in_slave_out_pin_out(mi_out), .master_in_slave_out_pin_oe(mi_oe),
    .error_interrupt(eint));

  ssl_far_model ssl_far_model_inst (.is_master(m_mst), .sclk_l(ln.sclk), .mosi_l(ln.mosi), .miso_l(ln.miso),
    .sclk_o(m_sclk), .data_o(m_data), .sclk_e(m_se), .mosi_e(m_moe), .miso_e(m_mie));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic tmo(input int n);
    if (n >= 400)
    begin
      err_total++;
      $display("[ERR] %0t no answer", $time);
      conclude();
    end
  endtask : tmo

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 400);
    tmo(n);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 400);
    tmo(n);
    r = hrdata;
  endtask : bus

  // Idle cycle after a write, though a read at once would already see the new value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge hclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask : rd

  task automatic ws(input int b, input logic v);
    int n;
    n = 0;
    do bus(1'b0, `SSL_OFS_STAT, 32'h0); while (r[b] !== v && ++n < 400);
    tmo(n);
  endtask : ws

  task automatic pulse_ack;
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : pulse_ack

  task automatic frame(input logic [15:0] tx, input int nb, input realtime half);
    ssl_far_model_inst.preset(tx);
    ssl_far_model_inst.xfer(nb, half);
    @(posedge hclk);
  endtask : frame

  task automatic sc_reset;
    rd(`SSL_OFS_CTRL, '1, 32'hf000);
    rd(`SSL_OFS_BAUD, '1, 32'h7);
    rd(`SSL_OFS_STAT, '1, 32'h1);
    rd(8'h1c, '1, 32'h0);
    chk({31'h0, eint}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask : sc_reset

  task automatic sc_master;
    wr(`SSL_OFS_CTRL, 32'h70f2);
    // Half-bit of five cycles covers the pin round trip through both synchronisers
    wr(`SSL_OFS_BAUD, 32'h4);
    wr(`SSL_OFS_DIR, 32'h3);
    wr(`SSL_OFS_EIC, 32'h2);
    wr(`SSL_OFS_CTRL, 32'h70f3);
    ssl_far_model_inst.preset(16'h3c00);
    wr(`SSL_OFS_TXBUF, 32'ha5);
    ws(1, 1'b1);
    rd(`SSL_OFS_RXBUF, '1, 32'h3c);
    chk({16'h0, ssl_far_model_inst.rx_q}, 32'ha5);
    ssl_far_model_inst.preset(16'h5aa5);
    wr(`SSL_OFS_TXBUF, 32'h96);
    ws(2, 1'b1);
    ws(0, 1'b1);
    wr(`SSL_OFS_TXBUF, 32'h69);
    ws(2, 1'b0);
    chk({16'h0, ssl_far_model_inst.rx_q}, 32'h9669);
    chk(32'(int'(ssl_far_model_inst.max_gap)), 32'h50);
    rd(`SSL_OFS_RXBUF, '1, 32'ha5);
    rd(`SSL_OFS_CTRL, 32'h400, 32'h400);
    chk({31'h0, eint}, 32'h1);
    pulse_ack();
    chk({31'h0, eint}, 32'h0);
    rd(`SSL_OFS_EIC, '1, 32'h2);
    rd(`SSL_OFS_CTRL, 32'h400, 32'h400);
    wr(`SSL_OFS_CTRL, 32'h7203);
    rd(`SSL_OFS_CTRL, '1, 32'h72f3);
    rd(`SSL_OFS_EIC, '1, 32'h3);
    wr(`SSL_OFS_EIC, 32'h1);
    // Interrupt output trails the enable by one register
    @(posedge hclk);
    chk({31'h0, eint}, 32'h0);
    wr(`SSL_OFS_EIC, 32'h2);
    wr(`SSL_OFS_CTRL, 32'h70f3);
    loop <= 1'b1;
    wr(`SSL_OFS_TXBUF, 32'h5a);
    ws(1, 1'b1);
    rd(`SSL_OFS_RXBUF, '1, 32'h5a);
    loop <= 1'b0;
  endtask : sc_master

  task automatic sc_slave;
    wr(`SSL_OFS_CTRL, 32'h70f0);
    wr(`SSL_OFS_DIR, 32'h4);
    m_mst <= 1'b1;
    wr(`SSL_OFS_BAUD, 32'h7);
    wr(`SSL_OFS_CTRL, 32'h70f1);
    wr(`SSL_OFS_TXBUF, 32'he1);
    frame(16'h4b00, 8, 62.5);
    chk({16'h0, ssl_far_model_inst.rx_q}, 32'he1);
    rd(`SSL_OFS_RXBUF, '1, 32'h4b);
    frame(16'h2d00, 8, 62.5);
    chk({16'h0, ssl_far_model_inst.rx_q}, 32'h4b);
    rd(`SSL_OFS_CTRL, 32'hf00, 32'h800);
    chk({31'h0, eint}, 32'h1);
    rd(`SSL_OFS_RXBUF, '1, 32'h2d);
    wr(`SSL_OFS_CTRL, 32'h70f1);
    pulse_ack();
  endtask : sc_slave

  // A short burst at over twice the rate, then a clean frame proves the channel recovered
  task automatic sc_baud;
    frame(16'h0000, 5, 24.0);
    // Data flips with the clock edge; the lone edge then times out as too slow
    ssl_far_model_inst.skew(62.5);
    repeat (40) @(posedge hclk);
    rd(`SSL_OFS_CTRL, 32'h100, 32'h100);
    rd(`SSL_OFS_CTRL, 32'h200, 32'h200);
    wr(`SSL_OFS_CTRL, 32'h70f1);
    pulse_ack();
    wr(`SSL_OFS_TXBUF, 32'h77);
    frame(16'h1e00, 8, 62.5);
    chk({16'h0, ssl_far_model_inst.rx_q}, 32'h77);
    rd(`SSL_OFS_RXBUF, '1, 32'h1e);
    wr(`SSL_OFS_CTRL, 32'h70f0);
    m_mst <= 1'b0;
    wr(`SSL_OFS_CTRL, 32'h70f2);
    wr(`SSL_OFS_DIR, 32'h3);
    wr(`SSL_OFS_TXBUF, 32'h33);
    repeat (40) @(posedge hclk);
    rd(`SSL_OFS_STAT, 32'h4, 32'h0);
  endtask : sc_baud

  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sc_reset();
    sc_master();
    sc_slave();
    sc_baud();
    conclude();
  end
endmodule : ssl_core_tb
`default_nettype wire
